/* File: design/ahp_cfg.svh */
// Constants for the parallel host port controller
`ifndef AHP_CFG_SVH
`define AHP_CFG_SVH
`define AHP_CLK_NS 4
`define AHP_CYC(ns) (((ns) + `AHP_CLK_NS - 1) / `AHP_CLK_NS)
`define AHP_SETUP_NS 70
`define AHP_HOLD_NS 30
`define AHP_IORDY_SAMPLE_NS 35
`define AHP_SYNC_LAT 2
`define AHP_REG8_NS 290
`define AHP_FIFO_DEPTH 16
`define AHP_DATA_W 16
`endif

/* File: design/ahp_pkg.sv */
// Types for the parallel host port controller
package ahp_pkg;
  typedef enum logic [2:0] {
    AHP_IDLE,
    AHP_SETUP,
    AHP_ACTIVE,
    AHP_WAIT,
    AHP_HOLD,
    AHP_RECOVER
  } ahp_state_t;
  typedef logic [7:0] ahp_cnt_t;
endpackage

/* File: design/ahp_fifo.sv */
// Small flip-flop FIFO with valid and ready on both sides
module ahp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;
  assign o_in_ready = count != (AW+1)'(DEPTH);
  assign o_out_valid = count != '0;
  assign o_out_data = mem[rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end
endmodule

/* File: design/ahp_host.sv */
// PIO host controller driving the card's parallel port
`include "ahp_cfg.svh"
module ahp_host
  import ahp_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [2:0] i_pio_mode,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic i_req_write,
  input wire logic i_req_cs_high,
  input wire logic [2:0] i_req_addr,
  input wire logic i_req_reg8,
  input wire logic [15:0] i_req_wdata,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [15:0] o_rd_data,
  output logic o_busy,
  output logic o_chip_select_low_n,
  output logic o_chip_select_high_n,
  output logic [2:0] o_host_address_lines,
  output logic o_host_read_strobe_n,
  output logic o_host_write_strobe_n,
  output logic o_register_select_line_n,
  input wire logic [15:0] i_host_data_bus,
  output logic [15:0] o_host_data_bus,
  output logic o_host_data_bus_oe,
  input wire logic i_iordy,
  input wire logic i_iocs16_n,
  output logic o_is16
);
  function automatic ahp_cnt_t cyc_min(input logic [2:0] m);
    unique case (m)
      3'h0: cyc_min = 8'(`AHP_CYC(600));
      3'h1: cyc_min = 8'(`AHP_CYC(383));
      3'h2: cyc_min = 8'(`AHP_CYC(240));
      3'h3: cyc_min = 8'(`AHP_CYC(180));
      3'h4: cyc_min = 8'(`AHP_CYC(120));
      3'h5: cyc_min = 8'(`AHP_CYC(100));
      default: cyc_min = 8'(`AHP_CYC(80));
    endcase
  endfunction
  function automatic ahp_cnt_t act_min(input logic [2:0] m, input logic r8);
    unique case (m)
      3'h0: act_min = r8 ? 8'(`AHP_CYC(`AHP_REG8_NS)) : 8'(`AHP_CYC(165));
      3'h1: act_min = r8 ? 8'(`AHP_CYC(`AHP_REG8_NS)) : 8'(`AHP_CYC(125));
      3'h2: act_min = r8 ? 8'(`AHP_CYC(`AHP_REG8_NS)) : 8'(`AHP_CYC(100));
      3'h3: act_min = 8'(`AHP_CYC(80));
      3'h4: act_min = 8'(`AHP_CYC(70));
      3'h5: act_min = 8'(`AHP_CYC(65));
      default: act_min = 8'(`AHP_CYC(55));
    endcase
  endfunction
  function automatic ahp_cnt_t rec_min(input logic [2:0] m);
    unique case (m)
      3'h0: rec_min = 8'h01;
      3'h1: rec_min = 8'h01;
      3'h2: rec_min = 8'h01;
      3'h3: rec_min = 8'(`AHP_CYC(70));
      3'h4: rec_min = 8'(`AHP_CYC(25));
      3'h5: rec_min = 8'(`AHP_CYC(25));
      default: rec_min = 8'(`AHP_CYC(20));
    endcase
  endfunction
  localparam ahp_cnt_t SETUP_C = 8'(`AHP_CYC(`AHP_SETUP_NS));
  localparam ahp_cnt_t HOLD_C = 8'(`AHP_CYC(`AHP_HOLD_NS));
  localparam ahp_cnt_t SAMPLE_C = 8'(`AHP_CYC(`AHP_IORDY_SAMPLE_NS) + `AHP_SYNC_LAT);

  ahp_state_t state, next_state;
  ahp_cnt_t cnt, next_cnt, total, next_total, act_len, next_act_len;
  logic [2:0] mode, next_mode;
  logic wr, next_wr, csh, next_csh;
  logic [2:0] addr, next_addr;
  logic [15:0] wdata, next_wdata, rdata, next_rdata;
  logic waited, next_waited, rd_push;
  logic is16, next_is16;
  logic [1:0] rdy_sync, cs16_sync;
  logic fifo_in_ready;

  // Two-flop synchronisers on the card's level pins
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdy_sync <= 2'h3;
      cs16_sync <= 2'h3;
    end else begin
      rdy_sync <= {rdy_sync[0], i_iordy};
      cs16_sync <= {cs16_sync[0], i_iocs16_n};
    end
  end

  always_comb begin
    next_state = state;
    next_cnt = cnt + 8'h01;
    next_total = total + 8'h01;
    next_act_len = act_len;
    next_mode = mode;
    next_wr = wr;
    next_csh = csh;
    next_addr = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_waited = waited;
    next_is16 = is16;
    rd_push = 1'b0;
    unique case (state)
      AHP_IDLE: begin
        next_cnt = '0;
        next_total = '0;
        if (i_req_valid && fifo_in_ready) begin
          next_state = AHP_SETUP;
          next_mode = i_pio_mode;
          next_wr = i_req_write;
          next_csh = i_req_cs_high;
          next_addr = i_req_addr;
          next_wdata = i_req_wdata;
          next_act_len = act_min(i_pio_mode, i_req_reg8);
          next_waited = 1'b0;
        end
      end
      AHP_SETUP: begin
        if (cnt >= SETUP_C - 8'h01) begin
          next_state = AHP_ACTIVE;
          next_cnt = '0;
          next_is16 = (mode <= 3'h2) ? !cs16_sync[1] : 1'b1;
        end
      end
      AHP_ACTIVE: begin
        if (mode <= 3'h4 && cnt == SAMPLE_C && !rdy_sync[1]) begin
          next_state = AHP_WAIT;
          next_waited = 1'b1;
        end else if (cnt >= act_len - 8'h01 && cnt >= SAMPLE_C) begin
          next_state = AHP_HOLD;
          next_cnt = '0;
          next_rdata = i_host_data_bus;
        end else if (cnt >= act_len - 8'h01 && mode > 3'h4) begin
          next_state = AHP_HOLD;
          next_cnt = '0;
          next_rdata = i_host_data_bus;
        end
      end
      AHP_WAIT: begin
        if (rdy_sync[1]) begin
          next_state = AHP_HOLD;
          next_cnt = '0;
          next_rdata = i_host_data_bus;
        end
      end
      AHP_HOLD: begin
        if (cnt >= HOLD_C - 8'h01) begin
          next_state = AHP_RECOVER;
          next_cnt = '0;
          rd_push = !wr;
        end
      end
      default: begin
        if (cnt >= rec_min(mode) - 8'h01 && total >= cyc_min(mode)) begin
          next_state = AHP_IDLE;
        end
      end
    endcase
    if (next_total == 8'hff) begin
      next_total = total;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= AHP_IDLE;
      cnt <= '0;
      total <= '0;
      act_len <= '0;
      mode <= '0;
      wr <= 1'b0;
      csh <= 1'b0;
      addr <= '0;
      wdata <= '0;
      rdata <= '0;
      waited <= 1'b0;
      is16 <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      total <= next_total;
      act_len <= next_act_len;
      mode <= next_mode;
      wr <= next_wr;
      csh <= next_csh;
      addr <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      waited <= next_waited;
      is16 <= next_is16;
    end
  end

  ahp_fifo #(
    .WIDTH(`AHP_DATA_W),
    .DEPTH(`AHP_FIFO_DEPTH)
  ) u_rd_fifo (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_in_valid(rd_push),
    .o_in_ready(fifo_in_ready),
    .i_in_data(is16 ? rdata : {8'h00, rdata[7:0]}),
    .o_out_valid(o_rd_valid),
    .i_out_ready(i_rd_ready),
    .o_out_data(o_rd_data)
  );

  logic in_cycle;
  assign in_cycle = state != AHP_IDLE && state != AHP_RECOVER;
  assign o_req_ready = state == AHP_IDLE && fifo_in_ready;
  assign o_busy = state != AHP_IDLE;
  assign o_chip_select_low_n = !(in_cycle && !csh);
  assign o_chip_select_high_n = !(in_cycle && csh);
  assign o_host_address_lines = addr;
  // No DMA or Ultra DMA burst is ever started
  assign o_register_select_line_n = 1'b1;
  assign o_host_read_strobe_n = !(!wr && (state == AHP_ACTIVE || state == AHP_WAIT));
  assign o_host_write_strobe_n = !(wr && (state == AHP_ACTIVE || state == AHP_WAIT));
  assign o_host_data_bus = wdata;
  assign o_host_data_bus_oe = wr && in_cycle;
  assign o_is16 = is16;

  // Strobe that ends from AHP_ACTIVE is never shorter than the active minimum; an exit from AHP_WAIT is not checked
  a_strobe_width: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state == AHP_ACTIVE && next_state == AHP_HOLD) |-> cnt >= act_len - 8'h01)
    else $error("strobe ended early");
  a_cycle_total: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state == AHP_RECOVER && next_state == AHP_IDLE) |-> total >= cyc_min(mode))
    else $error("cycle too short");
  a_wait_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state == AHP_WAIT && !rdy_sync[1]) |=> state == AHP_WAIT)
    else $error("wait left without ready");
  a_no_fast_wait: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    mode > 3'h4 |-> state != AHP_WAIT)
    else $error("wait in fast mode");
  a_is16_fast: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state == AHP_SETUP && next_state == AHP_ACTIVE && mode > 3'h2) |=> is16)
    else $error("select honoured in fast mode");
  a_one_strobe: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !(!o_host_read_strobe_n && !o_host_write_strobe_n))
    else $error("both strobes low");
  a_recovery: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $rose(state == AHP_RECOVER) |-> o_host_read_strobe_n && o_host_write_strobe_n)
    else $error("strobe in recovery");
  a_rdy_end: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (state == AHP_WAIT && rdy_sync[1]) |=> state == AHP_HOLD)
    else $error("strobe not ended after ready");
endmodule

/* File: bench/ahp_dev_model.sv */
// Behavioural card model answering PIO cycles
module ahp_dev_model (
  input wire logic i_mclk,
  input wire logic [2:0] i_mode,
  input wire logic [7:0] i_wait_cyc,
  input wire logic i_wide,
  input wire logic i_cs_low_n,
  input wire logic i_cs_high_n,
  input wire logic [2:0] i_addr,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [15:0] i_host_data,
  output logic [15:0] o_data,
  output logic o_iordy,
  output logic o_iocs16_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [16];
  logic sel;
  logic [3:0] idx;
  assign sel = !(i_cs_low_n && i_cs_high_n);
  assign idx = {!i_cs_high_n, i_addr};
  assign o_iocs16_n = !(sel && i_wide);
  initial o_iordy = 1'b1;
  initial o_data = 16'h0000;
  // Any stretched strobe is accepted
  always @(posedge i_wr_n) if (sel === 1'b1) mem[idx] <= i_host_data;
  always @(negedge i_rd_n) o_data = mem[idx];
  // Released bus shows the inverse of the last value
  always @(posedge i_rd_n) o_data = ~o_data;
  always @(negedge i_rd_n or negedge i_wr_n) begin
    if (i_wait_cyc != 8'h00 && i_mode < 3'h5) begin
      #4 o_iordy = 1'b0;
      repeat (i_wait_cyc) @(posedge i_mclk);
      o_iordy = 1'b1;
    end
  end
endmodule

/* File: bench/tb.sv */
// Self-checking bench for the parallel host port controller
`include "ahp_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk = 0, i_rst_n = 0, i_req_valid = 0, i_req_write = 0, i_req_cs_high = 0;
  logic i_req_reg8 = 0, i_rd_ready = 0, wide = 1;
  logic [2:0] i_pio_mode = 0, i_req_addr = 0;
  logic [15:0] i_req_wdata = 0, dev_data, o_rd_data, o_host_data_bus, i_host_data_bus;
  logic [7:0] wait_cyc = 0;
  logic [2:0] o_host_address_lines;
  logic o_req_ready, o_rd_valid, o_busy, o_csl_n, o_csh_n, o_rd_n, o_wr_n, o_reg_n;
  logic o_oe, i_iordy, i_iocs16_n, o_is16;
  int fail_count = 0, n_tests = 0, wid = 0, busy_len = 0, wcnt = 0, bcnt = 0;
  int t0 [7] = '{600, 383, 240, 180, 120, 100, 80};
  int t2 [7] = '{165, 125, 100, 80, 70, 65, 55};
  assign i_host_data_bus = o_oe ? o_host_data_bus : dev_data;
  always #2 i_mclk = ~i_mclk;
  ahp_host dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_pio_mode(i_pio_mode),
    .i_req_valid(i_req_valid), .o_req_ready(o_req_ready), .i_req_write(i_req_write),
    .i_req_cs_high(i_req_cs_high), .i_req_addr(i_req_addr), .i_req_reg8(i_req_reg8),
    .i_req_wdata(i_req_wdata), .o_rd_valid(o_rd_valid), .i_rd_ready(i_rd_ready),
    .o_rd_data(o_rd_data), .o_busy(o_busy), .o_chip_select_low_n(o_csl_n),
    .o_chip_select_high_n(o_csh_n), .o_host_address_lines(o_host_address_lines),
    .o_host_read_strobe_n(o_rd_n), .o_host_write_strobe_n(o_wr_n),
    .o_register_select_line_n(o_reg_n), .i_host_data_bus(i_host_data_bus),
    .o_host_data_bus(o_host_data_bus), .o_host_data_bus_oe(o_oe), .i_iordy(i_iordy),
    .i_iocs16_n(i_iocs16_n), .o_is16(o_is16));
  ahp_dev_model dev_u (.i_mclk(i_mclk), .i_mode(i_pio_mode), .i_wait_cyc(wait_cyc),
    .i_wide(wide), .i_cs_low_n(o_csl_n), .i_cs_high_n(o_csh_n),
    .i_addr(o_host_address_lines), .i_rd_n(o_rd_n), .i_wr_n(o_wr_n),
    .i_host_data(o_host_data_bus), .o_data(dev_data), .o_iordy(i_iordy),
    .o_iocs16_n(i_iocs16_n));
  // Strobe width and busy span in clock cycles
  always @(posedge i_mclk) begin
    if (o_rd_n === 1'b0 || o_wr_n === 1'b0) wcnt++;
    else if (wcnt != 0) begin
      wid = wcnt;
      wcnt = 0;
    end
    if (o_busy === 1'b1) bcnt++;
    else if (bcnt != 0) begin
      busy_len = bcnt;
      bcnt = 0;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic op(input logic wr, input logic csh, input logic [2:0] a, input logic [15:0] d);
    int n = 0;
    i_req_write = wr;
    i_req_cs_high = csh;
    i_req_addr = a;
    i_req_wdata = d;
    i_req_valid = 1;
    while (o_req_ready !== 1'b1 && n < 3000) begin
      @(posedge i_mclk);
      #1 n++;
    end
    @(posedge i_mclk);
    #1 i_req_valid = 0;
    n = 0;
    while (o_busy !== 1'b0 && n < 3000) begin
      @(posedge i_mclk);
      #1 n++;
    end
    @(posedge i_mclk);
    #1;
  endtask
  task automatic pop(input logic [15:0] exp);
    int n = 0;
    while (o_rd_valid !== 1'b1 && n < 100) begin
      @(posedge i_mclk);
      #1 n++;
    end
    chk(o_rd_data, exp);
    i_rd_ready = 1;
    @(posedge i_mclk);
    #1 i_rd_ready = 0;
  endtask
  task automatic t_rw();
    op(1, 0, 3'h5, 16'ha5c3);
    chk({13'h0000, o_host_address_lines}, 16'h0005);
    op(1, 1, 3'h5, 16'h3c5a);
    op(0, 0, 3'h5, 16'h0000);
    pop(16'ha5c3);
    op(0, 1, 3'h5, 16'h0000);
    pop(16'h3c5a);
  endtask
  task automatic t_modes();
    for (int m = 0; m < 7; m++) begin
      i_pio_mode = m[2:0];
      op(1, 0, 3'h1, 16'h1000 + m[15:0]);
      chk_rng(wid, `AHP_CYC(t2[m]), 400);
      chk_rng(busy_len, `AHP_CYC(t0[m]), 1000);
      op(0, 0, 3'h1, 16'h0000);
      pop(16'h1000 + m[15:0]);
    end
    i_pio_mode = 3'h0;
    i_req_reg8 = 1;
    op(0, 0, 3'h1, 16'h0000);
    i_req_reg8 = 0;
    chk_rng(wid, `AHP_CYC(`AHP_REG8_NS), 400);
    pop(16'h1006);
  endtask
  task automatic t_wait();
    wait_cyc = 8'd60;
    op(0, 0, 3'h1, 16'h0000);
    chk_rng(wid, 60, 400);
    pop(16'h1006);
    i_pio_mode = 3'h6;
    op(0, 0, 3'h1, 16'h0000);
    chk_rng(wid, `AHP_CYC(t2[6]), 59);
    pop(16'h1006);
    wait_cyc = 8'd0;
  endtask
  task automatic t_width();
    wide = 0;
    i_pio_mode = 3'h3;
    op(1, 0, 3'h2, 16'hbeef);
    op(0, 0, 3'h2, 16'h0000);
    chk(o_is16, 1'b1);
    pop(16'hbeef);
    i_pio_mode = 3'h0;
    op(0, 0, 3'h2, 16'h0000);
    chk(o_is16, 1'b0);
    pop(16'h00ef);
    wide = 1;
  endtask
  task automatic t_fifo();
    i_pio_mode = 3'h6;
    for (int i = 0; i < `AHP_FIFO_DEPTH; i++) op(0, 1, 3'h5, 16'h0000);
    chk(o_req_ready, 1'b0);
    for (int i = 0; i < `AHP_FIFO_DEPTH; i++) pop(16'h3c5a);
    chk(o_rd_valid, 1'b0);
    chk(o_reg_n, 1'b1);
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge i_mclk);
    #1 i_rst_n = 1;
    t_rw();
    t_modes();
    t_wait();
    t_width();
    t_fifo();
    report_and_stop();
  end
endmodule
